// >>> include/afe_regs.svh
`ifndef AFE_REGS_SVH
`define AFE_REGS_SVH

// ************************************************************
// Register map, byte offsets within the slave window.
// ************************************************************
`define AFE_OFF_DEST_HI      8'h00
`define AFE_OFF_DEST_LO      8'h04
`define AFE_OFF_API_OPT      8'h08
`define AFE_OFF_IRQ_STAT     8'h0c
`define AFE_OFF_IRQ_CLR      8'h10
`define AFE_OFF_IRQ_EN       8'h14
`define AFE_OFF_STATUS       8'h18
`define AFE_ADDR_LSB_W       8

// ************************************************************
// Reset values.
// ************************************************************
`define AFE_DEST_RST         32'h0000_0000
`define AFE_API_OPT_RST      8'h00

// ************************************************************
// Interrupt bit positions.
// ************************************************************
`define AFE_IRQ_W            3
`define AFE_IRQ_UPD          0
`define AFE_IRQ_RX           1
`define AFE_IRQ_DROP         2

// ************************************************************
// Frame constants.
// ************************************************************
`define AFE_START_DELIM      8'h7e
`define AFE_TYPE_ADDR_UPD    8'h8e
`define AFE_TYPE_RX64        8'h80
`define AFE_RESERVED_BYTE    8'h00
`define AFE_SHORT_ADDR_64BIT 16'hfffe
`define AFE_AO_LEGACY        8'h02
`define AFE_UPD_LEN          16'h0012
`define AFE_RX_HDR_LEN       16'h000b
`define AFE_UPD_HDR_BYTES    5'h12
`define AFE_RX_HDR_BYTES     5'h0b
`define AFE_RX_PAD           56'h0
`define AFE_RX_OPT_MASK      8'h06
`define AFE_CSUM_BASE        8'hff
`define AFE_MAX_PAYLOAD      65524

`endif

// >>> include/afe_pkg.sv
package afe_pkg;

   // ************************************************************
   // Emitter sequencing states.
   // ************************************************************
   typedef enum logic [2:0] {
      AFE_IDLE,
      AFE_LEN_HI,
      AFE_LEN_LO,
      AFE_HEAD,
      AFE_PAYLOAD,
      AFE_CSUM,
      AFE_DROP
   } afe_state_t;

   // ************************************************************
   // Complete state of the emitter.
   // ************************************************************
   typedef struct packed {
      afe_state_t   state;
      logic [31:0]  dest_addr_high;
      logic [31:0]  dest_addr_low;
      logic [7:0]   api_output_option;
      logic [2:0]   irq_stat;
      logic [2:0]   irq_en;
      logic [143:0] hdr;
      logic [4:0]   hdr_cnt;
      logic [15:0]  pay_cnt;
      logic [15:0]  frame_len;
      logic [7:0]   sum;
      logic [7:0]   out_byte;
      logic         out_valid;
      logic         bus_act;
      logic         bus_wr;
      logic [7:0]   bus_addr;
   } afe_regs_t;

endpackage : afe_pkg

// >>> verilog/afe_frame_emitter.sv
// Overview of operation
// R1: Sixteen-bit length follows delimiter, counts body bytes.
// R2: Last byte is 0xFF minus body sum.
// R3: Matching aggregator update rewrites destination, emits 0x8E.
// R4: Update frame offset four always zero.
// R5: New address at five, old at thirteen.
// R6: Emit 0x80 only for option 2, short 0xFFFE.
// R7: Sender 64-bit address from offset four.
// R8: Offset twelve carries negated dBm magnitude.
// R9: Options byte: bit0 reserved, 0x02, 0x04 flags.
// R10: Payload bytes from offset fourteen until checksum.
// R11: Host prefers newer receive frame unless legacy.
// R12: Bytes ascend by offset, multi-byte fields MSB first.
// R13: Host drops frames with bad checksum.

`timescale 1ns/1ps
`default_nettype none

`include "afe_regs.svh"

module afe_frame_emitter #(
   parameter int MAX_PAYLOAD = `AFE_MAX_PAYLOAD
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic              hreadyout,
   output logic              hresp,
   output logic [31:0]       hrdata,
   input  wire logic         agg_valid,
   output logic              agg_ready,
   input  wire logic [63:0]  agg_old_addr,
   input  wire logic [63:0]  agg_new_addr,
   input  wire logic         rx_valid,
   output logic              rx_ready,
   input  wire logic [63:0]  rx_src_addr,
   input  wire logic [15:0]  rx_src_short,
   input  wire logic [7:0]   rx_rssi,
   input  wire logic [7:0]   rx_options,
   input  wire logic [15:0]  rx_len,
   input  wire logic         rx_data_valid,
   output logic              rx_data_ready,
   input  wire logic [7:0]   rx_data,
   output logic              tx_valid,
   input  wire logic         tx_ready,
   output logic [7:0]        tx_data,
   output logic              irq
);

   // ************************************************************
   // Parameter check.
   // ************************************************************
   // The length field must still hold the fixed header plus payload.
   if (MAX_PAYLOAD < 1 || MAX_PAYLOAD > `AFE_MAX_PAYLOAD) begin : g_bad_max
      $error("MAX_PAYLOAD out of range");
   end

   // ************************************************************
   // State.
   // ************************************************************
   afe_pkg::afe_regs_t st;
   afe_pkg::afe_regs_t next_st;
   logic               slot_free;
   logic               dest_match;
   logic               rx_emit;
   logic [31:0]        status_word;

   // The output byte slot may be refilled in the cycle it is taken.
   assign slot_free   = !st.out_valid || tx_ready;
   assign dest_match  = ({st.dest_addr_high, st.dest_addr_low} == agg_old_addr);
   assign rx_emit     = (st.api_output_option == `AFE_AO_LEGACY)
                        && (rx_src_short == `AFE_SHORT_ADDR_64BIT)
                        && (rx_len <= 16'(MAX_PAYLOAD)); // R6
   assign status_word = {st.pay_cnt, 15'h0000, st.state != afe_pkg::AFE_IDLE};

   // ************************************************************
   // Handshakes and outputs.
   // ************************************************************
   assign hreadyout     = 1'b1;
   assign hresp         = 1'b0;
   assign agg_ready     = (st.state == afe_pkg::AFE_IDLE) && slot_free;
   assign rx_ready      = (st.state == afe_pkg::AFE_IDLE) && slot_free && !agg_valid;
   assign rx_data_ready = ((st.state == afe_pkg::AFE_PAYLOAD) && slot_free)
                          || (st.state == afe_pkg::AFE_DROP);
   assign tx_valid      = st.out_valid;
   assign tx_data       = st.out_byte;
   assign irq           = |(st.irq_stat & st.irq_en);

   // ************************************************************
   // Read data, a mux of registered state in the data phase.
   // ************************************************************
   always_comb begin
      hrdata = 32'h0000_0000;
      if (st.bus_act && !st.bus_wr) begin
         unique case (st.bus_addr)
            `AFE_OFF_DEST_HI:  hrdata = st.dest_addr_high;
            `AFE_OFF_DEST_LO:  hrdata = st.dest_addr_low;
            `AFE_OFF_API_OPT:  hrdata = {24'h00_0000, st.api_output_option};
            `AFE_OFF_IRQ_STAT: hrdata = {29'h0000_0000, st.irq_stat};
            `AFE_OFF_IRQ_EN:   hrdata = {29'h0000_0000, st.irq_en};
            `AFE_OFF_STATUS:   hrdata = status_word;
            default:           hrdata = 32'h0000_0000;
         endcase
      end
   end

   // ************************************************************
   // Next state.
   // ************************************************************
   always_comb begin
      next_st = st;
      if (st.out_valid && tx_ready) begin
         next_st.out_valid = 1'b0;
      end

      // Address phase capture.
      next_st.bus_act  = hsel && hready && htrans[1];
      next_st.bus_wr   = hwrite;
      next_st.bus_addr = haddr[`AFE_ADDR_LSB_W-1:0];

      // Data phase writes; hardware updates below take precedence.
      if (st.bus_act && st.bus_wr) begin
         unique case (st.bus_addr)
            `AFE_OFF_DEST_HI:  next_st.dest_addr_high    = hwdata;
            `AFE_OFF_DEST_LO:  next_st.dest_addr_low     = hwdata;
            `AFE_OFF_API_OPT:  next_st.api_output_option = hwdata[7:0];
            `AFE_OFF_IRQ_CLR:  next_st.irq_stat = st.irq_stat & ~hwdata[`AFE_IRQ_W-1:0];
            `AFE_OFF_IRQ_EN:   next_st.irq_en   = hwdata[`AFE_IRQ_W-1:0];
            default: begin
            end
         endcase
      end

      unique case (st.state)
         afe_pkg::AFE_IDLE: begin
            if (slot_free && agg_valid) begin
               if (dest_match) begin
                  next_st.dest_addr_high = agg_new_addr[63:32]; // R3
                  next_st.dest_addr_low  = agg_new_addr[31:0]; // R3
                  next_st.hdr = {`AFE_TYPE_ADDR_UPD, `AFE_RESERVED_BYTE,
                                 agg_new_addr, agg_old_addr}; // R3 R4 R5
                  next_st.hdr_cnt   = `AFE_UPD_HDR_BYTES;
                  next_st.pay_cnt   = 16'h0000;
                  next_st.frame_len = `AFE_UPD_LEN; // R1
                  next_st.out_byte  = `AFE_START_DELIM;
                  next_st.out_valid = 1'b1;
                  next_st.state     = afe_pkg::AFE_LEN_HI;
                  next_st.irq_stat[`AFE_IRQ_UPD] = 1'b1;
               end
            end else if (slot_free && rx_valid) begin
               next_st.pay_cnt = rx_len;
               if (rx_emit) begin
                  next_st.hdr = {`AFE_TYPE_RX64, rx_src_addr, rx_rssi,
                                 rx_options & `AFE_RX_OPT_MASK, `AFE_RX_PAD}; // R7 R8 R9
                  next_st.hdr_cnt   = `AFE_RX_HDR_BYTES;
                  next_st.frame_len = `AFE_RX_HDR_LEN + rx_len; // R1
                  next_st.out_byte  = `AFE_START_DELIM;
                  next_st.out_valid = 1'b1;
                  next_st.state     = afe_pkg::AFE_LEN_HI;
                  next_st.irq_stat[`AFE_IRQ_RX] = 1'b1;
               end else begin
                  // Refused packets still drain their payload so the source never hangs.
                  next_st.irq_stat[`AFE_IRQ_DROP] = 1'b1; // R6
                  if (rx_len != 16'h0000) begin
                     next_st.state = afe_pkg::AFE_DROP;
                  end
               end
            end
         end
         afe_pkg::AFE_LEN_HI: begin
            if (slot_free) begin
               next_st.out_byte  = st.frame_len[15:8]; // R12
               next_st.out_valid = 1'b1;
               next_st.state     = afe_pkg::AFE_LEN_LO;
            end
         end
         afe_pkg::AFE_LEN_LO: begin
            if (slot_free) begin
               next_st.out_byte  = st.frame_len[7:0]; // R12
               next_st.out_valid = 1'b1;
               next_st.sum       = 8'h00;
               next_st.state     = afe_pkg::AFE_HEAD;
            end
         end
         afe_pkg::AFE_HEAD: begin
            if (slot_free) begin
               next_st.out_byte  = st.hdr[143:136]; // R12
               next_st.out_valid = 1'b1;
               next_st.sum       = st.sum + st.hdr[143:136]; // R2
               next_st.hdr       = {st.hdr[135:0], 8'h00};
               next_st.hdr_cnt   = st.hdr_cnt - 5'h01;
               if (st.hdr_cnt == 5'h01) begin
                  next_st.state = (st.pay_cnt != 16'h0000) ? afe_pkg::AFE_PAYLOAD
                                                           : afe_pkg::AFE_CSUM;
               end
            end
         end
         afe_pkg::AFE_PAYLOAD: begin
            if (slot_free && rx_data_valid) begin
               next_st.out_byte  = rx_data; // R10
               next_st.out_valid = 1'b1;
               next_st.sum       = st.sum + rx_data; // R2
               next_st.pay_cnt   = st.pay_cnt - 16'h0001;
               if (st.pay_cnt == 16'h0001) begin
                  next_st.state = afe_pkg::AFE_CSUM; // R10
               end
            end
         end
         afe_pkg::AFE_CSUM: begin
            if (slot_free) begin
               next_st.out_byte  = `AFE_CSUM_BASE - st.sum; // R2
               next_st.out_valid = 1'b1;
               next_st.state     = afe_pkg::AFE_IDLE;
            end
         end
         afe_pkg::AFE_DROP: begin
            if (rx_data_valid) begin
               next_st.pay_cnt = st.pay_cnt - 16'h0001;
               if (st.pay_cnt == 16'h0001) begin
                  next_st.state = afe_pkg::AFE_IDLE;
               end
            end
         end
         default: begin
            next_st.state = afe_pkg::AFE_IDLE;
         end
      endcase
   end

   // ************************************************************
   // Registers.
   // ************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule : afe_frame_emitter

`default_nettype wire

// >>> verification/afe_checker.sv
`timescale 1ns/1ps
`default_nettype none
module afe_checker (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       tx_valid,
   input wire logic       tx_ready,
   input wire logic [7:0] tx_data
);
   // ************************************************************
   // Frame tracking from the handshakes on the byte stream.
   // ************************************************************
   logic [15:0] pos;
   logic [15:0] len;
   logic [7:0]  typ;
   logic [7:0]  sum;
   logic        last;
   assign last = pos > 16'd3 && pos == len + 16'd3;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pos <= '0;
         len <= '0;
         typ <= '0;
         sum <= '0;
      end else if (tx_valid && tx_ready) begin
         pos <= last ? 16'd0 : pos + 16'd1;
         sum <= (pos < 16'd3) ? 8'h00 : sum + tx_data;
         if (pos == 16'd1) len[15:8] <= tx_data;
         if (pos == 16'd2) len[7:0] <= tx_data;
         if (pos == 16'd3) typ <= tx_data;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_byte(int p);
      tx_valid && pos == p;
   endsequence
   a_frame_start: assert property (s_byte(0) |-> tx_data == 8'h7e)
      else $error("frame does not open with the delimiter");
   a_type_code: assert property (s_byte(3) |-> tx_data inside {8'h8e, 8'h80})
      else $error("unknown frame type");
   a_upd_length: assert property (s_byte(4) && typ == 8'h8e |-> len == 16'h0012)
      else $error("update frame length wrong");
   a_rx_length: assert property (s_byte(4) && typ == 8'h80 |-> len >= 16'h000b)
      else $error("receive frame length too short");
   a_upd_reserved: assert property (s_byte(4) && typ == 8'h8e |-> tx_data == 8'h00)
      else $error("reserved byte not zero");
   a_opt_reserved: assert property (s_byte(13) && typ == 8'h80 |-> (tx_data & 8'hf9) == 8'h00)
      else $error("options byte carries reserved bits");
   a_checksum_ok: assert property (tx_valid && last |-> tx_data == ~sum)
      else $error("checksum byte wrong");
   a_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("byte changed before it was taken");
endmodule : afe_checker
bind afe_frame_emitter afe_checker i_chk (.hclk(hclk), .hresetn(hresetn),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
`default_nettype wire

// >>> verification/afe_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module afe_host_model (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       slow,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   output logic            byte_stb,
   output logic [7:0]      byte_val,
   output logic [7:0]      good_frames,
   output logic [7:0]      bad_frames
);
   // ************************************************************
   // Host parser; a slow host takes one byte in four cycles.
   // ************************************************************
   logic [1:0]  div;
   logic [15:0] pos;
   logic [15:0] len;
   logic [7:0]  sum;
   assign byte_stb = tx_valid && tx_ready;
   assign byte_val = tx_data;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div <= '0;
         tx_ready <= 1'b0;
         pos <= '0;
         good_frames <= '0;
         bad_frames <= '0;
      end else begin
         div <= div + 2'd1;
         tx_ready <= !slow || div == 2'd3;
         if (byte_stb) begin
            pos <= (pos > 16'd3 && pos == len + 16'd3) ? 16'd0 : pos + 16'd1;
            sum <= (pos < 16'd3) ? 8'h00 : sum + tx_data;
            if (pos == 16'd1) len[15:8] <= tx_data;
            if (pos == 16'd2) len[7:0] <= tx_data;
            if (pos > 16'd3 && pos == len + 16'd3) begin
               if (tx_data == 8'hff - sum) good_frames <= good_frames + 8'd1;
               else bad_frames <= bad_frames + 8'd1;
            end
         end
      end
   end
endmodule : afe_host_model
`default_nettype wire

// >>> verification/afe_frame_emitter_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "afe_regs.svh"
`define CHK_EQ(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_count++; \
   $display("FAIL %s exp %h got %h", n, e, s); end end
module afe_frame_emitter_tb;
   localparam logic [63:0] OLDA = 64'h0013_a200_4052_aaaa;
   localparam logic [63:0] NEWA = 64'h0013_a200_4052_bbbb;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, agg_valid = 0, rx_valid = 0;
   logic        rx_data_valid = 0, slow = 0, hreadyout, hresp, agg_ready, rx_ready;
   logic        rx_data_ready, tx_valid, tx_ready, irq, byte_stb;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [63:0] agg_old_addr = 0, agg_new_addr = 0, rx_src_addr = 0;
   logic [15:0] rx_src_short = 0, rx_len = 0;
   logic [7:0]  rx_rssi = 0, rx_options = 0, rx_data = 0, tx_data, byte_val, e_b;
   logic [7:0]  good_frames, bad_frames, bq[$], exp_q[$];
   int          err_count = 0, comparisons = 0;
   always #50 hclk = ~hclk;
   afe_frame_emitter #(.MAX_PAYLOAD(16)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .agg_valid(agg_valid),
      .agg_ready(agg_ready), .agg_old_addr(agg_old_addr), .agg_new_addr(agg_new_addr),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_src_addr(rx_src_addr),
      .rx_src_short(rx_src_short), .rx_rssi(rx_rssi), .rx_options(rx_options),
      .rx_len(rx_len), .rx_data_valid(rx_data_valid), .rx_data_ready(rx_data_ready),
      .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .irq(irq));
   afe_host_model i_host (.hclk(hclk), .hresetn(hresetn), .slow(slow), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .byte_stb(byte_stb), .byte_val(byte_val),
      .good_frames(good_frames), .bad_frames(bad_frames));
   // ************************************************************
   // Drivers; every expected byte is queued before the request goes out.
   // ************************************************************
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : ahb
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0000_0000, r);
      `CHK_EQ(n, e, r)
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask : wr
   task automatic put64(input logic [63:0] v);
      for (int i = 56; i >= 0; i -= 8) bq.push_back(v[i +: 8]);
   endtask : put64
   task automatic exp_frame();
      logic [7:0] s;
      s = 8'h00;
      exp_q.push_back(8'h7e);
      exp_q.push_back(8'(bq.size() >> 8));
      exp_q.push_back(8'(bq.size()));
      foreach (bq[i]) begin
         exp_q.push_back(bq[i]);
         s += bq[i];
      end
      exp_q.push_back(8'hff - s);
   endtask : exp_frame
   task automatic agg(input logic [63:0] o, input logic [63:0] n);
      agg_valid <= 1'b1;
      agg_old_addr <= o;
      agg_new_addr <= n;
      do @(posedge hclk); while (agg_ready !== 1'b1);
      agg_valid <= 1'b0;
      // One idle edge keeps a following call from re-raising valid in the same step.
      @(posedge hclk);
   endtask : agg
   task automatic rx(input logic [15:0] sh, input logic [7:0] opt, input int n, input logic emit);
      logic [63:0] src;
      logic [7:0]  pay[$];
      src = {$urandom, $urandom};
      for (int i = 0; i < n; i++) pay.push_back(8'($urandom));
      bq = {8'h80};
      put64(src);
      bq.push_back(8'h28);
      bq.push_back(opt & 8'h06);
      bq = {bq, pay};
      if (emit) exp_frame();
      rx_valid <= 1'b1;
      rx_src_addr <= src;
      rx_src_short <= sh;
      rx_rssi <= 8'h28;
      rx_options <= opt;
      rx_len <= 16'(n);
      do @(posedge hclk); while (rx_ready !== 1'b1);
      rx_valid <= 1'b0;
      foreach (pay[i]) begin
         rx_data_valid <= 1'b1;
         rx_data <= pay[i];
         do @(posedge hclk); while (rx_data_ready !== 1'b1);
      end
      rx_data_valid <= 1'b0;
      @(posedge hclk);
   endtask : rx
   task automatic print_verdict();
      if (err_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   always @(posedge hclk) begin
      if (byte_stb === 1'b1) begin
         e_b = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx;
         `CHK_EQ("tx_data", e_b, byte_val)
      end
   end
   initial begin
      repeat (20000) @(posedge hclk);
      err_count++;
      print_verdict();
   end
   // ************************************************************
   // Scenarios.
   // ************************************************************
   initial begin
      void'($urandom(82));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(`AFE_OFF_DEST_HI, 32'h0000_0000, "dest_hi");
      rd(`AFE_OFF_API_OPT, 32'h0000_0000, "api_opt");
      rd(8'h1c, 32'h0000_0000, "unmapped");
      wr(`AFE_OFF_DEST_HI, OLDA[63:32]);
      wr(`AFE_OFF_DEST_LO, OLDA[31:0]);
      wr(`AFE_OFF_IRQ_EN, 32'h0000_0001);
      bq = {8'h8e, 8'h00};
      put64(NEWA);
      put64(OLDA);
      exp_frame();
      agg(OLDA, NEWA);
      agg(OLDA, ~NEWA);
      repeat (40) @(posedge hclk);
      `CHK_EQ("irq", 1'b1, irq)
      rd(`AFE_OFF_DEST_HI, NEWA[63:32], "dest_hi");
      rd(`AFE_OFF_DEST_LO, NEWA[31:0], "dest_lo");
      rd(`AFE_OFF_IRQ_STAT, 32'h0000_0001, "irq_stat");
      wr(`AFE_OFF_IRQ_CLR, 32'h0000_0001);
      rx(16'hfffe, 8'h02, 3, 1'b0);
      rd(`AFE_OFF_IRQ_STAT, 32'h0000_0004, "irq_stat");
      `CHK_EQ("irq", 1'b0, irq)
      wr(`AFE_OFF_API_OPT, 32'h0000_0002);
      slow <= 1'b1;
      for (int k = 0; k < 8; k++) rx(16'hfffe, {5'($urandom), k[2:0]}, k % 5, 1'b1);
      rx(16'h1234, 8'h00, 3, 1'b0);
      rx(16'hfffe, 8'h00, 17, 1'b0);
      repeat (3000) if (exp_q.size() != 0) @(posedge hclk);
      // The host counters update on the same edge that pops the last byte.
      repeat (2) @(posedge hclk);
      `CHK_EQ("left", 0, exp_q.size())
      `CHK_EQ("good", 8'd9, good_frames)
      `CHK_EQ("bad", 8'd0, bad_frames)
      print_verdict();
   end
endmodule : afe_frame_emitter_tb
`default_nettype wire
